// >>> core/cais_top.sv
// Per-channel alarm status registers with clear-upon-read change events and interrupt output
//
// How it works
// - One status register per channel, four addresses
// - Bit 5 shows live lock-lost state
// - Bit 4 shows live signal-lost state
// - Bit 1 latches lock change, clear-upon-read
// - Bit 0 latches signal change, clear-upon-read
// - Lock event interrupts only when enabled
// - Signal event interrupts only when enabled
// - Bits 7,6,3,2 read zero, ignore writes
//
// Register layout, the same for every channel:
//   7..6  zero
//   5     lock lost, live
//   4     signal lost, live
//   3..2  zero
//   1     lock change, cleared by the read that returns it
//   0     signal change, cleared by the read that returns it
//
// There is no write path: every bit is read-only, so writes have nothing
// to land on. The interrupt enables sit in a configuration register kept
// elsewhere and arrive here as two level inputs per channel.
// Reads may come every cycle and each is answered one cycle later.
`include "cais_defines.svh"

// Address decode of the read port onto a channel index
module cais_decode #(
	parameter int NUM_CH = 4,
	parameter int IDX_W  = 2
) (
	input  wire cais_pkg::cais_addr_t addr,
	output logic                      hit,
	output logic [IDX_W-1:0]          idx
);

	if (IDX_W < 2) begin : g_bad_idx_w
		$error("cais_decode: IDX_W must be at least 2");
	end

	// A slot beyond NUM_CH decodes as unmapped: it reads zero, clears nothing
	always_comb begin
		hit = 1'h0;
		idx = '0;
		if (addr == `CAIS_CH0_STATUS_OFS) begin
			hit = 1'h1;
			idx = IDX_W'(0);
		end else if (addr == `CAIS_CH1_STATUS_OFS) begin
			hit = NUM_CH > 1;
			idx = IDX_W'(1);
		end else if (addr == `CAIS_CH2_STATUS_OFS) begin
			hit = NUM_CH > 2;
			idx = IDX_W'(2);
		end else if (addr == `CAIS_CH3_STATUS_OFS) begin
			hit = NUM_CH > 3;
			idx = IDX_W'(3);
		end
	end

endmodule : cais_decode

// Marks the cycles in which change detection may run
module cais_prime (
	input  wire logic mclk,
	input  wire logic srst,
	output logic      primed
);

	logic primed_q;

	// First cycle after reset only samples the levels, so a channel already
	// in alarm at reset does not report a spurious change
	always_ff @(posedge mclk) begin
		if (srst) begin
			primed_q <= 1'h0;
		end else begin
			primed_q <= 1'h1;
		end
	end

	assign primed = primed_q;

endmodule : cais_prime

// One channel: previous levels, change detection and latched events
module cais_chan (
	input  wire logic                   mclk,
	input  wire logic                   srst,
	input  wire logic                   primed,
	input  wire cais_pkg::cais_alarm_s  alarm,
	input  wire cais_pkg::cais_irq_en_s irq_en,
	input  wire logic                   clr,
	output cais_pkg::cais_event_s       events,
	output logic                        irq
);

	cais_pkg::cais_alarm_s prev_q;
	cais_pkg::cais_event_s event_q;
	cais_pkg::cais_event_s event_d;
	logic                  lock_chg;
	logic                  sig_chg;
	logic                  lock_irq;
	logic                  sig_irq;

	// Previous levels are the reference for change detection
	always_ff @(posedge mclk) begin
		if (srst) begin
			prev_q <= '0;
		end else begin
			prev_q <= alarm;
		end
	end

	// Both directions of a level count as a change
	always_comb begin
		lock_chg = primed
			&& (alarm.lock_lost_state != prev_q.lock_lost_state);
		sig_chg  = primed
			&& (alarm.signal_lost_state != prev_q.signal_lost_state);
	end

	// Set wins over the clearing read, so a change in the read cycle survives
	always_comb begin
		event_d.lock_change_event   = lock_chg
			|| (event_q.lock_change_event && !clr);
		event_d.signal_change_event = sig_chg
			|| (event_q.signal_change_event && !clr);
	end

	always_ff @(posedge mclk) begin
		if (srst) begin
			event_q <= '0;
		end else begin
			event_q <= event_d;
		end
	end

	// Enables gate only the interrupt; the event bits latch regardless
	always_comb begin
		lock_irq = event_q.lock_change_event && irq_en.lock_change_irq_enable;
		sig_irq  = event_q.signal_change_event && irq_en.signal_change_irq_enable;
	end

	assign events = event_q;
	assign irq    = lock_irq || sig_irq;

endmodule : cais_chan

// Read answer: assembles the selected word and registers it
module cais_rd_port (
	input  wire logic                  mclk,
	input  wire logic                  srst,
	input  wire logic                  rd,
	input  wire cais_pkg::cais_alarm_s live,
	input  wire cais_pkg::cais_event_s events,
	output cais_pkg::cais_rd_rsp_s     rsp
);

	cais_pkg::cais_data_t word_d;
	cais_pkg::cais_data_t data_q;
	logic                 valid_q;

	// Unused bits keep the zero of the unmapped word
	always_comb begin
		word_d                         = `CAIS_UNMAPPED_READ;
		word_d[`CAIS_LOCK_STATE_BIT]   = live.lock_lost_state;
		word_d[`CAIS_SIGNAL_STATE_BIT] = live.signal_lost_state;
		word_d[`CAIS_LOCK_EVENT_BIT]   = events.lock_change_event;
		word_d[`CAIS_SIGNAL_EVENT_BIT] = events.signal_change_event;
	end

	// Valid is a one-cycle pulse after each taken read
	always_ff @(posedge mclk) begin
		if (srst) begin
			valid_q <= 1'h0;
		end else begin
			valid_q <= rd;
		end
	end

	// Data holds until the next read, so a slow host can still pick it up
	always_ff @(posedge mclk) begin
		if (srst) begin
			data_q <= `CAIS_STATUS_RESET;
		end else if (rd) begin
			data_q <= word_d;
		end
	end

	assign rsp.valid = valid_q;
	assign rsp.data  = data_q;

endmodule : cais_rd_port

// Interrupt request: any channel with an enabled event holds it up
module cais_irq_merge #(
	parameter int NUM_CH = 4
) (
	input  wire logic [NUM_CH-1:0] chan_irq,
	output logic                   irq
);

	// A level, not a pulse: it falls only once every enabled event is read
	always_comb begin
		irq = 1'h0;
		for (int i = 0; i < NUM_CH; i++) begin
			irq = irq || chan_irq[i];
		end
	end

endmodule : cais_irq_merge

// Status registers of all channels behind the register read port
module cais_top #(
	parameter int NUM_CH = 4
) (
	input  wire logic                   mclk,
	input  wire logic                   srst,
	input  wire cais_pkg::cais_alarm_s  alarm_in [NUM_CH],
	input  wire cais_pkg::cais_irq_en_s irq_en   [NUM_CH],
	input  wire cais_pkg::cais_rd_req_s rd_req,
	output cais_pkg::cais_rd_rsp_s      rd_rsp,
	output logic                        alarm_irq
);

	// The address map has four channel slots; more cannot be decoded
	if (NUM_CH < 1 || NUM_CH > 4) begin : g_bad_num_ch
		$error("cais_top: NUM_CH must lie between 1 and 4");
	end

	localparam int IDX_W = 2;

	logic                  primed;
	logic                  hit;
	logic [IDX_W-1:0]      hit_idx;
	logic                  rd_hit;
	logic [NUM_CH-1:0]     clr;
	logic [NUM_CH-1:0]     chan_irq;
	cais_pkg::cais_event_s events [NUM_CH];
	cais_pkg::cais_alarm_s live_sel;
	cais_pkg::cais_event_s event_sel;

	cais_decode #(
		.NUM_CH (NUM_CH),
		.IDX_W  (IDX_W)
	) u_decode (
		.addr (rd_req.addr),
		.hit  (hit),
		.idx  (hit_idx)
	);

	assign rd_hit = rd_req.rd && hit;

	cais_prime u_prime (
		.mclk   (mclk),
		.srst   (srst),
		.primed (primed)
	);

	// Per-channel state; a channel beyond NUM_CH does not exist at all
	for (genvar c = 0; c < NUM_CH; c++) begin : g_ch
		// Only a read that hits this channel clears its events
		assign clr[c] = rd_hit && (hit_idx == IDX_W'(c));

		cais_chan u_chan (
			.mclk   (mclk),
			.srst   (srst),
			.primed (primed),
			.alarm  (alarm_in[c]),
			.irq_en (irq_en[c]),
			.clr    (clr[c]),
			.events (events[c]),
			.irq    (chan_irq[c])
		);
	end

	// Selected channel's live levels and events; zero when nothing is hit
	always_comb begin
		live_sel  = '0;
		event_sel = '0;
		for (int i = 0; i < NUM_CH; i++) begin
			if (hit && (hit_idx == IDX_W'(i))) begin
				live_sel  = alarm_in[i];
				event_sel = events[i];
			end
		end
	end

	cais_rd_port u_rd_port (
		.mclk   (mclk),
		.srst   (srst),
		.rd     (rd_req.rd),
		.live   (live_sel),
		.events (event_sel),
		.rsp    (rd_rsp)
	);

	cais_irq_merge #(
		.NUM_CH (NUM_CH)
	) u_irq_merge (
		.chan_irq (chan_irq),
		.irq      (alarm_irq)
	);

endmodule : cais_top

// >>> core/cais_defines.svh
// Register offsets, field positions and reset values of the channel alarm status registers
`ifndef CAIS_DEFINES_SVH
`define CAIS_DEFINES_SVH

`define CAIS_CH0_STATUS_OFS     8'h0A
`define CAIS_CH1_STATUS_OFS     8'h12
`define CAIS_CH2_STATUS_OFS     8'h1A
`define CAIS_CH3_STATUS_OFS     8'h22

`define CAIS_LOCK_STATE_BIT     5
`define CAIS_SIGNAL_STATE_BIT   4
`define CAIS_LOCK_EVENT_BIT     1
`define CAIS_SIGNAL_EVENT_BIT   0

`define CAIS_STATUS_RESET       8'h00
`define CAIS_UNMAPPED_READ      8'h00

`endif

// >>> core/cais_pkg.sv
// Types shared by the channel alarm status block
package cais_pkg;

	typedef logic [7:0] cais_addr_t;
	typedef logic [7:0] cais_data_t;

	// Live alarm levels of one channel
	typedef struct packed {
		logic lock_lost_state;
		logic signal_lost_state;
	} cais_alarm_s;

	// Interrupt enables of one channel, held in its configuration register
	typedef struct packed {
		logic lock_change_irq_enable;
		logic signal_change_irq_enable;
	} cais_irq_en_s;

	// Latched change events of one channel
	typedef struct packed {
		logic lock_change_event;
		logic signal_change_event;
	} cais_event_s;

	// Register read request from the host interface
	typedef struct packed {
		logic       rd;
		cais_addr_t addr;
	} cais_rd_req_s;

	// Register read answer
	typedef struct packed {
		logic       valid;
		cais_data_t data;
	} cais_rd_rsp_s;

endpackage : cais_pkg

// >>> bench/cais_asserts.sv
// Checker on the ports of cais_top
`include "cais_defines.svh"
module cais_chk (
	input wire logic                   mclk,
	input wire logic                   srst,
	input wire cais_pkg::cais_alarm_s  alarm_in [4],
	input wire cais_pkg::cais_irq_en_s irq_en   [4],
	input wire cais_pkg::cais_rd_req_s rd_req,
	input wire cais_pkg::cais_rd_rsp_s rd_rsp,
	input wire logic                   alarm_irq
);
	timeunit 1ns;
	timeprecision 1ns;
	default clocking @(posedge mclk); endclocking
	default disable iff (srst);
	sequence s_rd_ch0_quiet;
		rd_req.rd && rd_req.addr == `CAIS_CH0_STATUS_OFS && $stable(alarm_in[0]);
	endsequence
	sequence s_clear_ch0;
		s_rd_ch0_quiet ##1 $stable(alarm_in[0]) ##1 s_rd_ch0_quiet;
	endsequence
	sequence s_sig_chg_ch1;
		!$past(srst) && $changed(alarm_in[1].signal_lost_state)
		##1 irq_en[1].signal_change_irq_enable;
	endsequence
	property p_clr; s_clear_ch0 |=> rd_rsp.data[1:0] == 2'h0; endproperty
	a_clr: assert property (p_clr) else $error("event not cleared by read");
	property p_live;
		rd_req.rd && rd_req.addr == `CAIS_CH0_STATUS_OFS |=> rd_rsp.data[5:4]
			== $past({alarm_in[0].lock_lost_state, alarm_in[0].signal_lost_state});
	endproperty
	a_live: assert property (p_live) else $error("live bits wrong");
	property p_irq_sig; s_sig_chg_ch1 |-> alarm_irq; endproperty
	a_irq_sig: assert property (p_irq_sig) else $error("enabled change no irq");
	property p_mask;
		{irq_en[0], irq_en[1], irq_en[2], irq_en[3]} == 8'h00 |-> !alarm_irq;
	endproperty
	a_mask: assert property (p_mask) else $error("irq while all masked");
	property p_hold; !rd_req.rd |=> $stable(rd_rsp.data); endproperty
	a_hold: assert property (p_hold) else $error("read data moved");
	property p_ans; rd_req.rd |=> rd_rsp.valid; endproperty
	a_ans: assert property (p_ans) else $error("read unanswered");
	property p_one; !rd_req.rd |=> !rd_rsp.valid; endproperty
	a_one: assert property (p_one) else $error("stray answer");
	property p_rsv; rd_rsp.valid |-> !rd_rsp.data[7:6] && !rd_rsp.data[3:2]; endproperty
	a_rsv: assert property (p_rsv) else $error("unused bit set");
endmodule : cais_chk
bind cais_top cais_chk u_chk (.mclk, .srst, .alarm_in, .irq_en, .rd_req, .rd_rsp, .alarm_irq);

// >>> bench/cais_host.sv
// Host processor model issuing register reads
module cais_host (
	input  wire logic                   mclk,
	output cais_pkg::cais_rd_req_s      rd_req,
	input  wire cais_pkg::cais_rd_rsp_s rd_rsp
);
	timeunit 1ns;
	timeprecision 1ns;
	initial rd_req = '0;
	// Called on an edge; released address is inverted so stale values show
	task automatic rd(input logic [7:0] a, output logic [7:0] d);
		rd_req <= {1'h1, a};
		@(posedge mclk);
		rd_req <= {1'h0, ~a};
		#1 d = rd_rsp.valid ? rd_rsp.data : 'x;
		@(posedge mclk);
	endtask : rd
endmodule : cais_host

// >>> bench/testbench.sv
// Testbench for the channel alarm status block
module testbench;
	timeunit 1ns;
	timeprecision 1ns;
	logic                   mclk, srst, alarm_irq;
	cais_pkg::cais_alarm_s  alarm_in [4];
	cais_pkg::cais_irq_en_s irq_en [4];
	cais_pkg::cais_rd_req_s rd_req;
	cais_pkg::cais_rd_rsp_s rd_rsp;
	logic [7:0]             d;
	logic [7:0]             ofs [4] = '{8'h0A, 8'h12, 8'h1A, 8'h22};
	int                     bad_count, compares, tmo;
	cais_top uut (.mclk, .srst, .alarm_in, .irq_en, .rd_req, .rd_rsp, .alarm_irq);
	cais_host host (.mclk, .rd_req, .rd_rsp);
	initial begin
		mclk = 1'h0;
		forever #50 mclk = ~mclk;
	end
	always @(posedge mclk) begin
		tmo <= tmo + 1;
		if (tmo == 3000) begin
			bad_count++;
			complete_run();
		end
	end
	task automatic chk(input string n, input logic [7:0] s, e);
		compares++;
		if (s !== e) begin
			bad_count++;
			$display("BAD %s exp %h got %h", n, e, s);
		end
	endtask : chk
	task automatic complete_run;
		$display("compares %0d bad %0d", compares, bad_count);
		if (bad_count == 0 && compares > 0) $display("Run complete: PASS");
		else $display("Run complete: FAIL");
		$finish;
	endtask : complete_run
	initial begin
		srst = 1'h1;
		for (int c = 0; c < 4; c++) begin
			alarm_in[c] = '0;
			irq_en[c] = '0;
		end
		repeat (5) @(posedge mclk);
		srst <= 1'h0;
		for (int c = 0; c < 4; c++) begin
			host.rd(ofs[c], d);
			chk("reset", d, 8'h00);
			alarm_in[c] <= '1;
			repeat (3) @(posedge mclk);
			host.rd(ofs[c], d);
			chk("event", d, 8'h33);
			host.rd(ofs[c], d);
			chk("clear", d, 8'h30);
		end
		$display("test events done");
		alarm_in[0] <= 2'h1;
		repeat (3) @(posedge mclk);
		chk("irq", {7'h00, alarm_irq}, 8'h00);
		irq_en[0] <= 2'h2;
		repeat (2) @(posedge mclk);
		chk("irq", {7'h00, alarm_irq}, 8'h01);
		host.rd(ofs[0], d);
		chk("lock", d, 8'h12);
		chk("irq", {7'h00, alarm_irq}, 8'h00);
		irq_en[1] <= 2'h1;
		alarm_in[1] <= 2'h2;
		repeat (3) @(posedge mclk);
		chk("irq", {7'h00, alarm_irq}, 8'h01);
		host.rd(8'h0B, d);
		chk("unmapped", d, 8'h00);
		host.rd(ofs[1], d);
		chk("signal", d, 8'h21);
		chk("irq", {7'h00, alarm_irq}, 8'h00);
		$display("test interrupt done");
		irq_en[2] <= 2'h3;
		alarm_in[2] <= 2'h0;
		repeat (2) @(posedge mclk);
		chk("irq", {7'h00, alarm_irq}, 8'h01);
		srst <= 1'h1;
		repeat (2) @(posedge mclk);
		srst <= 1'h0;
		host.rd(ofs[2], d);
		chk("rereset", d, 8'h00);
		chk("irq", {7'h00, alarm_irq}, 8'h00);
		$display("test mid reset done");
		complete_run();
	end
endmodule : testbench
